// ---- core/code_slewer.sv ----
`timescale 1ns/100ps
// walks one channel's code toward its target at a fixed tick rate
module code_slewer #(
	parameter int W     = 10,
	parameter int DIV_W = 16
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rst_n,
	input  wire logic [W-1:0]     i_target,
	input  wire logic [3:0]       i_step,
	input  wire logic [DIV_W-1:0] i_period,
	input  wire logic             i_load,
	input  wire logic [W-1:0]     i_load_code,
	output logic      [W-1:0]     o_code
);
	logic [DIV_W-1:0] div_q;
	logic             tick;
	logic [W:0]       up_sum;
	logic [W-1:0]     step_w;

	// one-cycle enable every i_period+1 cycles
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || div_q == '0)
			div_q <= i_period;
		else
			div_q <= div_q - 1'b1;
	end
	assign tick   = (div_q == '0);
	assign step_w = W'(i_step);
	assign up_sum = {1'b0, o_code} + {1'b0, step_w};

	// clamp at the target so a coarse step never overshoots
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			o_code <= '0;
		else if (i_load)
			o_code <= i_load_code;
		else if (tick && o_code < i_target) begin
			if (up_sum > {1'b0, i_target})
				o_code <= i_target;
			else
				o_code <= up_sum[W-1:0];
		end else if (tick && o_code > i_target) begin
			if (o_code - i_target < step_w)
				o_code <= i_target;
			else
				o_code <= o_code - step_w;
		end
	end
endmodule

// ---- core/pmbus_status_and_host_interface.sv ----
`timescale 1ns/100ps
`include "pmbus_status_defines.svh"
module pmbus_status_and_host_interface import pmbus_status_pkg::*; #(
	parameter int CH          = 4,
	parameter int CW          = 10,
	parameter int DIV_W       = 16,
	parameter int TIMEOUT_CYC = `I2C_TIMEOUT_CYC
) (
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	input  wire logic              i_proto_valid,
	input  wire logic [1:0]        i_proto_det,
	input  wire logic              i_req_valid,
	input  wire logic              i_req_write,
	input  wire logic [7:0]        i_req_cmd,
	input  wire logic [15:0]       i_req_wdata,
	input  wire logic              i_bad_clocks,
	input  wire logic              i_read_no_cmd,
	input  wire logic              i_timeout_en,
	input  wire logic              i_scl_low,
	input  wire logic              i_nvm_gpio_sdo,
	input  wire logic              i_nvm_pd_alt,
	input  wire logic              i_nvm_pu_code_en,
	input  wire logic [15:0]       i_nvm_pu_code,
	input  wire logic [CH-1:0]     i_chan_on,
	input  wire logic [2*CH-1:0]   i_margin_op,
	input  wire logic [15:0]       i_margin_high,
	input  wire logic [15:0]       i_margin_low,
	input  wire logic [15:0]       i_nominal,
	input  wire logic [3:0]        i_step,
	input  wire logic [DIV_W-1:0]  i_period,
	output logic      [1:0]        o_proto,
	output logic                   o_proto_locked,
	output logic                   o_sdo_en,
	output logic      [15:0]       o_rdata,
	output logic                   o_rvalid,
	output logic                   o_fault_flag,
	output logic                   o_nvm_save,
	output logic                   o_bus_timeout,
	output logic      [CH-1:0]     o_hiz,
	output logic      [CH*CW-1:0]  o_code
);
	lock_e           lock_q;
	proto_e          proto_q;
	logic            fault_q;
	logic            fault_evt;
	logic            fault_clr;
	logic            known_cmd;
	logic            bad_data;
	logic            pm_req;
	logic            pu_q;
	logic [1:0]      scl_sync_q;
	logic [31:0]     to_cnt_q;
	logic [15:0]     rdata_d;
	logic [15:0]     fault_word;

	// protocol captured once; only a power cycle (reset) reopens it
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			lock_q  <= LK_WAIT;
			proto_q <= PROTO_NONE;
		end else begin
			unique case (lock_q)
				LK_WAIT: begin
					if (i_proto_valid) begin
						lock_q  <= LK_HELD;
						proto_q <= proto_e'(i_proto_det);
					end
				end
				LK_HELD: begin
					lock_q <= LK_HELD;
				end
			endcase
		end
	end
	assign o_proto        = proto_q;
	assign o_proto_locked = (lock_q == LK_HELD);

	// spi readback driver enabled only if stored config gives gpio that role
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			o_sdo_en <= 1'b0;
		else
			o_sdo_en <= (proto_q == PROTO_SPI) && i_nvm_gpio_sdo;
	end

	// fault sources; 78h and 98h decode ignores the page entirely
	assign pm_req    = i_req_valid && (proto_q == PROTO_PMBUS);
	assign known_cmd = (i_req_cmd == `CMD_FAULT_STATUS) ||
	                   (i_req_cmd == `CMD_BUS_REVISION) ||
	                   (i_req_cmd == `ADDR_COMMON_TRIG);
	assign bad_data  = i_req_write && ((i_req_cmd == `CMD_BUS_REVISION) ||
	                   ((i_req_cmd == `ADDR_COMMON_TRIG) && i_req_wdata != `TRIG_SAVE_VAL));
	assign fault_evt = (proto_q == PROTO_PMBUS) && (i_bad_clocks || i_read_no_cmd ||
	                   (pm_req && (!known_cmd || bad_data)));
	assign fault_clr = pm_req && i_req_write && (i_req_cmd == `CMD_FAULT_STATUS) &&
	                   i_req_wdata[`FAULT_BIT];

	// sticky flag; a fault in the clearing cycle wins over the clear
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			fault_q <= 1'b0;
		else if (fault_evt)
			fault_q <= 1'b1;
		else if (fault_clr)
			fault_q <= 1'b0;
	end
	assign o_fault_flag = fault_q;

	// don't-care bits always read zero
	always_comb begin
		fault_word             = 16'h0000;
		fault_word[`FAULT_BIT] = fault_q;
		rdata_d                = 16'h0000;
		if (i_req_cmd == `CMD_FAULT_STATUS)
			rdata_d = fault_word;
		else if (i_req_cmd == `CMD_BUS_REVISION)
			rdata_d = `BUS_REVISION_VAL;
	end

	// read answer one cycle after the request
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_rdata  <= 16'h0000;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req_valid && !i_req_write;
			if (i_req_valid && !i_req_write)
				o_rdata <= rdata_d;
		end
	end

	// save strobe: trigger register takes only the save value
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			o_nvm_save <= 1'b0;
		else
			o_nvm_save <= i_req_valid && i_req_write &&
			              (i_req_cmd == `ADDR_COMMON_TRIG) &&
			              (i_req_wdata == `TRIG_SAVE_VAL);
	end

	// scl pin level crosses in through two flops
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			scl_sync_q <= 2'b00;
		else
			scl_sync_q <= {scl_sync_q[0], i_scl_low};
	end

	// clock held low too long releases the stalled transfer, once per stall
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			to_cnt_q      <= '0;
			o_bus_timeout <= 1'b0;
		end else begin
			o_bus_timeout <= 1'b0;
			if (!i_timeout_en || proto_q == PROTO_SPI || !scl_sync_q[1])
				to_cnt_q <= '0;
			else if (to_cnt_q == 32'(TIMEOUT_CYC - 1)) begin
				to_cnt_q      <= to_cnt_q + 1'b1;
				o_bus_timeout <= 1'b1;
			end else if (to_cnt_q < 32'(TIMEOUT_CYC))
				to_cnt_q <= to_cnt_q + 1'b1;
		end
	end

	// power-up load one cycle after reset release; straps read only then
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			pu_q <= 1'b1;
		else
			pu_q <= 1'b0;
	end

	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : g_ch
			logic [1:0]    op;
			logic [CW-1:0] target;
			assign op = i_margin_op[2*g +: 2];
			// codes taken from the top bits of the left-aligned word
			always_comb begin
				unique case (margin_op_e'(op))
					OP_HIGH:    target = i_margin_high[`CODE_MSB:`CODE_LSB];
					OP_LOW:     target = i_margin_low[`CODE_MSB:`CODE_LSB];
					default:    target = i_nominal[`CODE_MSB:`CODE_LSB];
				endcase
			end
			// hi-z until switched on, unless stored config chose otherwise
			always_ff @(posedge i_mclk) begin
				if (!i_rst_n)
					o_hiz[g] <= 1'b1;
				else if (pu_q)
					o_hiz[g] <= !(i_nvm_pd_alt || i_nvm_pu_code_en);
				else if (i_chan_on[g])
					o_hiz[g] <= 1'b0;
			end
			code_slewer #(
				.W     (CW),
				.DIV_W (DIV_W)
			) u_slew (
				.i_mclk      (i_mclk),
				.i_rst_n     (i_rst_n),
				.i_target    (pu_q ? i_nvm_pu_code[`CODE_MSB:`CODE_LSB] : target),
				.i_step      (i_step),
				.i_period    (i_period),
				.i_load      (pu_q && i_nvm_pu_code_en),
				.i_load_code (i_nvm_pu_code[`CODE_MSB:`CODE_LSB]),
				.o_code      (o_code[g*CW +: CW])
			);
		end
	endgenerate

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	a_fault_sets: assert property (fault_evt |=> o_fault_flag)
		else $error("fault event did not set flag");
	a_fault_holds: assert property (o_fault_flag && !fault_clr |=> o_fault_flag)
		else $error("fault flag dropped without clear");
	a_fault_clears: assert property (fault_clr && !fault_evt |=> !o_fault_flag)
		else $error("fault flag not cleared by write of one");
	// read word reflects the flag as it stood at the request edge
	a_fault_read: assert property (i_req_valid && !i_req_write &&
		i_req_cmd == `CMD_FAULT_STATUS
		|=> o_rvalid && o_rdata == {6'h00, $past(o_fault_flag), 9'h000})
		else $error("fault status read wrong");
	a_rev_read: assert property (i_req_valid && !i_req_write &&
		i_req_cmd == `CMD_BUS_REVISION
		|=> o_rvalid && o_rdata == `BUS_REVISION_VAL)
		else $error("revision read wrong");
	a_rev_write: assert property (pm_req && i_req_write &&
		i_req_cmd == `CMD_BUS_REVISION |=> o_fault_flag)
		else $error("write to revision not flagged");
	a_proto_lock: assert property (o_proto_locked |=> o_proto_locked && $stable(o_proto))
		else $error("protocol changed after lock");
	a_sdo_gate: assert property (o_sdo_en |-> $past(i_nvm_gpio_sdo) &&
		o_proto == PROTO_SPI)
		else $error("readback driver enabled without config");
	a_save_pulse: assert property (i_req_valid && i_req_write &&
		i_req_cmd == `ADDR_COMMON_TRIG && i_req_wdata == `TRIG_SAVE_VAL
		|=> o_nvm_save ##1 !o_nvm_save)
		else $error("save strobe missing");
	// straps are sampled on the first edge out of reset, so judge them there
	a_hiz_default: assert property ($rose(i_rst_n) &&
		!i_nvm_pd_alt && !i_nvm_pu_code_en |=> o_hiz == '1)
		else $error("channels not hi-z after power-up");
	a_timeout_off: assert property (!i_timeout_en |=> !o_bus_timeout)
		else $error("timeout fired while disabled");

	c_fault_clear: cover property (o_fault_flag ##1 fault_clr ##1 !o_fault_flag);
	c_set_wins: cover property (fault_evt && fault_clr);
	c_save: cover property (o_nvm_save);
	c_pmbus_lock: cover property ($rose(o_proto_locked) && o_proto == PROTO_PMBUS);
endmodule

// ---- core/pmbus_status_defines.svh ----
`ifndef PMBUS_STATUS_DEFINES_SVH
`define PMBUS_STATUS_DEFINES_SVH
`define CMD_FAULT_STATUS 8'h78
`define CMD_BUS_REVISION 8'h98
`define ADDR_COMMON_TRIG 8'h20
`define BUS_REVISION_VAL 16'h2200
`define FAULT_BIT        9
`define TRIG_SAVE_VAL    16'h0002
`define CODE_MSB         15
`define CODE_LSB         6
`define CLK_PERIOD_NS    5
`define I2C_TIMEOUT_MS   25
`define I2C_TIMEOUT_CYC  ((`I2C_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// ---- core/pmbus_status_pkg.sv ----
package pmbus_status_pkg;
	// gray along detect order
	typedef enum logic [1:0] {
		PROTO_NONE  = 2'b00,
		PROTO_I2C   = 2'b01,
		PROTO_PMBUS = 2'b11,
		PROTO_SPI   = 2'b10
	} proto_e;
	typedef enum logic [1:0] {
		OP_NOMINAL = 2'b00,
		OP_HIGH    = 2'b01,
		OP_LOW     = 2'b11
	} margin_op_e;
	typedef enum logic {
		LK_WAIT = 1'b0,
		LK_HELD = 1'b1
	} lock_e;
endpackage

// ---- test/host_model.sv ----
`timescale 1ns/100ps
// host side: one decoded transaction at a time, spi clock pacing is left to the front end
// the broadcast address is never issued as a target
module host_model (
	input  wire logic        i_mclk,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_rvalid,
	output logic             o_req_valid,
	output logic             o_req_write,
	output logic [7:0]       o_req_cmd,
	output logic [15:0]      o_req_wdata
);
	initial begin
		o_req_valid = 1'b0;
		o_req_write = 1'b0;
		o_req_cmd   = 8'h00;
		o_req_wdata = 16'h0000;
	end
	// released lines show the inverse so a stale word never passes
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] rd, output logic rv);
		@(posedge i_mclk);
		o_req_valid <= 1'b1;
		o_req_write <= w;
		o_req_cmd   <= c;
		o_req_wdata <= d;
		@(posedge i_mclk);
		o_req_valid <= 1'b0;
		o_req_cmd   <= ~c;
		o_req_wdata <= ~d;
		#1;
		rd = i_rdata;
		rv = i_rvalid;
	endtask
endmodule

// ---- test/test_pmbus_status_and_host_interface.sv ----
`timescale 1ns/100ps
module test_pmbus_status_and_host_interface;
	logic i_mclk, i_rst_n, pv, rq, wr, bad, rnc, toen, scl, gsdo, pdalt, puen;
	logic [1:0] pdet, proto;
	logic [7:0] cmd, mop;
	logic [15:0] wd, pucode, rdata, rd, per;
	logic [3:0] chon, hiz, stp;
	logic [39:0] code;
	logic rvalid, locked, sdo, fault, save, tmo, rv;
	int mismatches, comparisons, cyc;
	// small timeout count keeps the stall scenario short
	pmbus_status_and_host_interface #(.TIMEOUT_CYC(20)) u_pmbus_status_and_host_interface (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_proto_valid(pv), .i_proto_det(pdet),
		.i_req_valid(rq), .i_req_write(wr), .i_req_cmd(cmd), .i_req_wdata(wd),
		.i_bad_clocks(bad), .i_read_no_cmd(rnc), .i_timeout_en(toen), .i_scl_low(scl),
		.i_nvm_gpio_sdo(gsdo), .i_nvm_pd_alt(pdalt), .i_nvm_pu_code_en(puen),
		.i_nvm_pu_code(pucode), .i_chan_on(chon), .i_margin_op(mop),
		.i_margin_high(16'ha540), .i_margin_low(16'h0500), .i_nominal(16'h5540),
		.i_step(stp), .i_period(per), .o_proto(proto), .o_proto_locked(locked),
		.o_sdo_en(sdo), .o_rdata(rdata), .o_rvalid(rvalid), .o_fault_flag(fault),
		.o_nvm_save(save), .o_bus_timeout(tmo), .o_hiz(hiz), .o_code(code));
	host_model u_host_model (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid),
		.o_req_valid(rq), .o_req_write(wr), .o_req_cmd(cmd), .o_req_wdata(wd));
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// reset acts as the power cycle, stored config sampled just after release
	task automatic do_reset(input logic pd, input logic pu);
		@(posedge i_mclk);
		i_rst_n <= 1'b0;
		pdalt <= pd;
		puen <= pu;
		tick(8);
		i_rst_n <= 1'b1;
		tick(3);
	endtask
	task automatic lock(input logic [1:0] p);
		@(posedge i_mclk);
		pv <= 1'b1;
		pdet <= p;
		@(posedge i_mclk);
		pv <= 1'b0;
		pdet <= ~p;
		tick(1);
	endtask
	task automatic t_lock;
		lock(2'b11);
		chk("proto", 16'h0003, {14'h0, proto});
		chk("locked", 16'h0001, {15'h0, locked});
		lock(2'b10);
		chk("proto kept", 16'h0003, {14'h0, proto});
		chk("sdo outside spi", 16'h0000, {15'h0, sdo});
	endtask
	task automatic t_regs;
		u_host_model.xfer(1'b0, 8'h98, 16'h0000, rd, rv);
		chk("revision", 16'h2200, rd);
		chk("rvalid", 16'h0001, {15'h0, rv});
		u_host_model.xfer(1'b1, 8'h98, 16'hffff, rd, rv);
		chk("fault ro write", 16'h0001, {15'h0, fault});
		u_host_model.xfer(1'b0, 8'h98, 16'h0000, rd, rv);
		chk("revision kept", 16'h2200, rd);
		u_host_model.xfer(1'b0, 8'h78, 16'h0000, rd, rv);
		chk("status set", 16'h0200, rd);
		u_host_model.xfer(1'b1, 8'h78, 16'hfdff, rd, rv);
		chk("zero no clear", 16'h0001, {15'h0, fault});
		u_host_model.xfer(1'b1, 8'h78, 16'h0200, rd, rv);
		u_host_model.xfer(1'b0, 8'h78, 16'h0000, rd, rv);
		chk("status clear", 16'h0000, rd);
	endtask
	task automatic t_faults;
		for (int i = 0; i < 4; i++) begin
			@(posedge i_mclk);
			bad <= (i == 0);
			rnc <= (i == 1);
			@(posedge i_mclk);
			bad <= 1'b0;
			rnc <= 1'b0;
			if (i == 2) u_host_model.xfer(1'b1, 8'h55, 16'h1234, rd, rv);
			if (i == 3) u_host_model.xfer(1'b1, 8'h20, 16'h0001, rd, rv);
			tick(1);
			chk("fault cause", 16'h0001, {15'h0, fault});
			u_host_model.xfer(1'b1, 8'h78, 16'h0200, rd, rv);
			chk("fault cleared", 16'h0000, {15'h0, fault});
		end
	endtask
	task automatic t_save;
		u_host_model.xfer(1'b1, 8'h20, 16'h0002, rd, rv);
		chk("save pulse", 16'h0001, {15'h0, save});
		tick(1);
		chk("save end", 16'h0000, {15'h0, save});
	endtask
	// a clock line held low must give one pulse only when enabled
	task automatic t_tmo;
		int n;
		for (int en = 0; en < 2; en++) begin
			n = 0;
			@(posedge i_mclk);
			toen <= en[0];
			scl <= 1'b1;
			repeat (60) begin
				tick(1);
				n += tmo;
			end
			scl <= 1'b0;
			chk("timeouts", en[15:0], n[15:0]);
		end
	endtask
	// code must stay between start and target and reach the target within e-2 to e+3 cycles of the stepped count
	task automatic t_slew;
		logic [9:0] tg [3] = '{10'h295, 10'h014, 10'h155};
		logic [1:0] op [3] = '{2'b01, 2'b11, 2'b00};
		logic [3:0] sv [3] = '{4'h2, 4'h4, 4'h2};
		logic [15:0] pr [3] = '{16'h0000, 16'h0000, 16'h0001};
		logic [9:0] s, lo, hi;
		int n, e;
		chon <= 4'h1;
		tick(2);
		chk("hiz on", 16'h000e, {12'h0, hiz});
		for (int k = 0; k < 3; k++) begin
			s = code[9:0];
			lo = (s < tg[k]) ? s : tg[k];
			hi = (s < tg[k]) ? tg[k] : s;
			mop <= {6'h0, op[k]};
			stp <= sv[k];
			per <= pr[k];
			n = 0;
			while (code[9:0] !== tg[k] && n < 400) begin
				tick(1);
				n++;
				if (code[9:0] < lo || code[9:0] > hi) chk("in range", 16'h0, 16'h1);
			end
			chk("target", {6'h0, tg[k]}, {6'h0, code[9:0]});
			// ticks needed, the last one clamped, times the divider period
			e = (int'(hi - lo) + sv[k] - 1) / sv[k] * (pr[k] + 1);
			chk("step count", 16'h1, {15'h0, n <= e + 3 && n >= e - 2});
		end
	endtask
	task automatic t_power;
		do_reset(1'b0, 1'b1);
		for (int c = 0; c < 4; c++)
			chk("pu code", 16'h0155, {6'h0, code[c*10 +: 10]});
		chk("pu hiz", 16'h0000, {12'h0, hiz});
		chk("unlocked", 16'h0000, {15'h0, locked});
		lock(2'b10);
		chk("sdo spi", 16'h0001, {15'h0, sdo});
		gsdo <= 1'b0;
		tick(2);
		chk("sdo unset", 16'h0000, {15'h0, sdo});
		gsdo <= 1'b1;
		do_reset(1'b1, 1'b0);
		chk("pd alt hiz", 16'h0000, {12'h0, hiz});
		// faults are a pmbus matter only
		lock(2'b01);
		chk("proto i2c", 16'h0001, {14'h0, proto});
		@(posedge i_mclk);
		bad <= 1'b1;
		@(posedge i_mclk);
		bad <= 1'b0;
		tick(1);
		chk("no fault i2c", 16'h0000, {15'h0, fault});
	endtask
	initial begin
		{pv, bad, rnc, toen, scl, pdalt, puen} = 7'h00;
		gsdo = 1'b1;
		pdet = 2'b00;
		pucode = 16'h5540;
		chon = 4'h0;
		mop = 8'h00;
		stp = 4'h2;
		per = 16'h0000;
		i_rst_n = 1'b0;
		tick(8);
		i_rst_n <= 1'b1;
		tick(3);
		chk("reset hiz", 16'h000f, {12'h0, hiz});
		chk("reset fault", 16'h0000, {15'h0, fault});
		t_lock();
		t_regs();
		t_faults();
		t_save();
		t_tmo();
		t_slew();
		t_power();
		report_and_stop();
	end
	// cut a hang short
	initial begin
		cyc = 0;
		forever begin
			@(posedge i_mclk);
			cyc++;
			if (cyc == 5000) begin
				mismatches++;
				report_and_stop();
			end
		end
	end
endmodule
